// ==== logic/highway_arbiter_pkg.sv ====
package highway_arbiter_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int REG_ADDR_W = 32;
    localparam int REG_DATA_W = 32;
    localparam logic [REG_ADDR_W-1:0] RAISE_DELAYS_ADDR = 32'h0010010C;
    localparam logic [REG_ADDR_W-1:0] BW_WEIGHT_ADDR = 32'h00100104;
    localparam int RAISE_DELAYS_W = 20;
    localparam int BW_WEIGHT_W = 18;
    localparam logic [RAISE_DELAYS_W-1:0] RAISE_DELAYS_RESET = 20'h00000;
    localparam logic [BW_WEIGHT_W-1:0] BW_WEIGHT_RESET = 18'h00000;

    // ----------------------------------------------------------------
    // Raise delay fields and timing
    // ----------------------------------------------------------------
    localparam int DELAY_W = 5;
    localparam int RAISE_STEP_SHIFT = 4;
    localparam int RAISE_CNT_W = DELAY_W + RAISE_STEP_SHIFT;
    localparam int TIMED_UNITS = 4;
    localparam int BD_DELAY_LSB = 15;
    localparam int HB_DELAY_LSB = 10;
    localparam int CC_DELAY_LSB = 5;
    localparam int PO_DELAY_LSB = 0;

    // ----------------------------------------------------------------
    // Requester slots
    // ----------------------------------------------------------------
    localparam int NUM_UNITS = 9;
    localparam int MAIN_PROCESSOR = 0;
    localparam int IMAGE_COPROCESSOR_UNIT = 1;
    localparam int BITSTREAM_DECODER_UNIT = 2;
    localparam int HOST_BUS_UNIT = 3;
    localparam int CAMERA_CAPTURE_UNIT = 4;
    localparam int PICTURE_OUTPUT_UNIT = 5;
    localparam int SOUND_CAPTURE_UNIT = 6;
    localparam int SOUND_PLAYBACK_UNIT = 7;
    localparam int BOOT_LOADER_UNIT = 8;

    localparam int TIMED_UNIT [TIMED_UNITS] = '{
        BITSTREAM_DECODER_UNIT, HOST_BUS_UNIT, CAMERA_CAPTURE_UNIT, PICTURE_OUTPUT_UNIT};
    localparam int TIMED_LSB [TIMED_UNITS] = '{
        BD_DELAY_LSB, HB_DELAY_LSB, CC_DELAY_LSB, PO_DELAY_LSB};
endpackage

// ==== logic/highway_dual_priority_arbiter.sv ====
`timescale 1ns/10ps
module highway_dual_priority_arbiter
    import highway_arbiter_pkg::*;
#(
    parameter int N = NUM_UNITS,
    parameter int OWN_W = $clog2(N)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] req_high,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    output logic [REG_DATA_W-1:0] reg_rdata,
    output logic [N-1:0] grant,
    output logic [OWN_W-1:0] owner,
    output logic grant_high
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [OWN_W-1:0] owner;
        logic [N-1:0] grant;
        logic win_high;
        logic [RAISE_DELAYS_W-1:0] raise_delays;
        logic [BW_WEIGHT_W-1:0] bw_weight;
        logic [TIMED_UNITS-1:0][RAISE_CNT_W-1:0] wait_cnt;
        logic [REG_DATA_W-1:0] rdata;
    } state_s;

    state_s st;
    state_s next_st;
    logic [TIMED_UNITS-1:0] timed_high;
    logic [N-1:0] eff_high;
    logic any_high;
    logic [N-1:0] cand;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Priority class of each request
    // ----------------------------------------------------------------
    for (genvar t = 0; t < TIMED_UNITS; t++) begin : g_timed
        logic [RAISE_CNT_W-1:0] limit;
        assign limit = {st.raise_delays[TIMED_LSB[t] +: DELAY_W], {RAISE_STEP_SHIFT{1'b0}}};
        assign timed_high[t] = st.wait_cnt[t] >= limit;

        property count_up_p;
            req[TIMED_UNIT[t]] && !timed_high[t] && !next_st.grant[TIMED_UNIT[t]]
                |=> st.wait_cnt[t] == $past(st.wait_cnt[t]) + 1'b1;
        endproperty
        wait_count_up_a: assert property (count_up_p)
            else $error("wait counter did not advance");
        wait_clear_a: assert property (!req[TIMED_UNIT[t]] |=> st.wait_cnt[t] == '0)
            else $error("wait counter not cleared without request");
        // Only a delay write may pull a raised request back to low
        raise_hold_a: assert property (timed_high[t] && !reg_write
            && req[TIMED_UNIT[t]] && !next_st.grant[TIMED_UNIT[t]] |=> timed_high[t])
            else $error("raised request fell back to low");
    end

    always_comb begin
        eff_high = '1;
        eff_high[IMAGE_COPROCESSOR_UNIT] = req_high[IMAGE_COPROCESSOR_UNIT];
        for (int t = 0; t < TIMED_UNITS; t++) begin
            eff_high[TIMED_UNIT[t]] = timed_high[t];
        end
    end

    // ----------------------------------------------------------------
    // Arbitration and registers
    // ----------------------------------------------------------------
    always_comb begin
        int idx;
        logic found;
        logic [OWN_W-1:0] win;
        idx = 0;
        found = 1'b0;
        win = st.owner;
        next_st = st;
        any_high = |(req & eff_high);
        cand = any_high ? (req & eff_high) : req;
        // Search starts after the owner, so the owner sits last in the list
        for (int k = 1; k <= N; k++) begin
            idx = (int'(st.owner) + k) % N;
            if (!found && cand[idx]) begin
                found = 1'b1;
                win = idx[OWN_W-1:0];
            end
        end
        next_st.grant = '0;
        next_st.win_high = 1'b0;
        // Owner is left alone when nothing is pending
        if (found) begin
            next_st.grant[win] = 1'b1;
            next_st.owner = win;
            next_st.win_high = any_high;
        end
        // A grant restarts the wait; a raised wait stops counting
        for (int t = 0; t < TIMED_UNITS; t++) begin
            if (!req[TIMED_UNIT[t]] || next_st.grant[TIMED_UNIT[t]]) begin
                next_st.wait_cnt[t] = '0;
            end else if (!timed_high[t]) begin
                next_st.wait_cnt[t] = st.wait_cnt[t] + 1'b1;
            end
        end
        // Delays are best written while idle; a lowered delay spares no
        // request already counting against the old one
        if (reg_write && reg_addr == RAISE_DELAYS_ADDR) begin
            next_st.raise_delays = reg_wdata[RAISE_DELAYS_W-1:0];
        end
        if (reg_write && reg_addr == BW_WEIGHT_ADDR) begin
            next_st.bw_weight = reg_wdata[BW_WEIGHT_W-1:0];
        end
        if (reg_read) begin
            next_st.rdata = '0;
            if (reg_addr == RAISE_DELAYS_ADDR) begin
                next_st.rdata[RAISE_DELAYS_W-1:0] = st.raise_delays;
            end else if (reg_addr == BW_WEIGHT_ADDR) begin
                next_st.rdata[BW_WEIGHT_W-1:0] = st.bw_weight;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.raise_delays <= RAISE_DELAYS_RESET;
            st.bw_weight <= BW_WEIGHT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign grant = st.grant;
    assign owner = st.owner;
    assign grant_high = st.win_high;
    assign reg_rdata = st.rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence high_pending_s;
        |(req & eff_high);
    endsequence
    sequence high_granted_s;
        grant_high && |(grant & $past(req & eff_high));
    endsequence
    sequence low_pending_s;
        |req && !(|(req & eff_high));
    endsequence
    sequence low_granted_s;
        !grant_high && |(grant & $past(req));
    endsequence

    single_grant_a: assert property ($onehot0(grant))
        else $error("more than one grant");
    high_first_a: assert property (high_pending_s |=> high_granted_s)
        else $error("low request beat a high one");
    low_class_a: assert property (low_pending_s |=> low_granted_s)
        else $error("low class grant marked high");
    grant_req_a: assert property (|req |=> |(grant & $past(req)))
        else $error("pending request left without grant");
    rotate_a: assert property (|(cand & ~next_st.grant & ~grant) && |grant
        |=> grant != $past(grant))
        else $error("rotation did not move on");
    alternate_a: assert property ($onehot(grant) && |(cand & ~grant)
        |=> !(|(grant & $past(grant))))
        else $error("owner kept while another waited");
    keep_owner_a: assert property (!(|req) |=> $stable(owner) && grant == '0)
        else $error("owner changed with no request");
    sole_regrant_a: assert property ($onehot(req) |=> grant == $past(req))
        else $error("sole requester not granted again");
    owner_match_a: assert property (|grant |-> grant == (N'(1) << owner))
        else $error("owner does not match grant");
    idle_class_a: assert property (!(|req) |=> !grant_high)
        else $error("idle cycle marked high");

    // ----------------------------------------------------------------
    // Class checks
    // ----------------------------------------------------------------
    fixed_high_a: assert property (eff_high[MAIN_PROCESSOR]
        && eff_high[SOUND_CAPTURE_UNIT] && eff_high[SOUND_PLAYBACK_UNIT]
        && eff_high[BOOT_LOADER_UNIT])
        else $error("fixed high unit seen as low");
    coproc_own_a: assert property (eff_high[IMAGE_COPROCESSOR_UNIT]
        == req_high[IMAGE_COPROCESSOR_UNIT])
        else $error("coprocessor class not its own");
    zero_delay_a: assert property (st.raise_delays == '0 |-> &timed_high)
        else $error("zero delay did not give high class");

    // ----------------------------------------------------------------
    // Register checks
    // ----------------------------------------------------------------
    // Read data is registered, so every check looks one edge after the strobe
    delay_write_a: assert property (reg_write && reg_addr == RAISE_DELAYS_ADDR
        |=> st.raise_delays == $past(reg_wdata[RAISE_DELAYS_W-1:0]))
        else $error("raise delays not written");
    delay_hold_a: assert property (!(reg_write && reg_addr == RAISE_DELAYS_ADDR)
        |=> $stable(st.raise_delays))
        else $error("raise delays changed without a write");
    delay_read_a: assert property (reg_read && reg_addr == RAISE_DELAYS_ADDR
        && !reg_write |=> reg_rdata == REG_DATA_W'($past(st.raise_delays)))
        else $error("raise delays read back wrong");
    bw_write_a: assert property (reg_write && reg_addr == BW_WEIGHT_ADDR
        |=> st.bw_weight == $past(reg_wdata[BW_WEIGHT_W-1:0]))
        else $error("bandwidth weights not written");
    unmapped_read_a: assert property (reg_read && reg_addr != RAISE_DELAYS_ADDR
        && reg_addr != BW_WEIGHT_ADDR |=> reg_rdata == '0)
        else $error("unmapped read not zero");
endmodule

// ==== verification/highway_dual_priority_arbiter_tb_top.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Bench
// ----------------------------------------
module highway_dual_priority_arbiter_tb_top;
    import highway_arbiter_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [8:0] want = 9'h000;
    logic [8:0] req, req_high, grant;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
    logic reg_write = 1'b0, reg_read = 1'b0, grant_high;
    logic [3:0] owner;
    int errors = 0, n_compared = 0, n, slot, exp_owner = 0;
    // Rows: request mask, expected grant one cycle later
    logic [17:0] rows [10] = '{{9'h003, 9'h001}, {9'h011, 9'h010}, {9'h011, 9'h001},
        {9'h1C0, 9'h040}, {9'h1C0, 9'h080}, {9'h1C0, 9'h100}, {9'h101, 9'h001},
        {9'h000, 9'h000}, {9'h00C, 9'h004}, {9'h020, 9'h020}};
    int slots [6] = '{1, 2, 3, 4, 5, 5};
    logic [31:0] delays [6] = '{32'h0, 32'h8000, 32'h400, 32'h20, 32'h1, 32'h1F};
    int lat [6] = '{16, 16, 16, 16, 16, 496};
    always #5 clock = ~clock;
    request_units #(.COP_WAIT(16)) units (.clock(clock), .rst(rst), .want(want), .req(req),
        .req_high(req_high));
    highway_dual_priority_arbiter uut (.clock(clock), .rst(rst), .req(req),
        .req_high(req_high), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .grant(grant), .owner(owner), .grant_high(grant_high));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t %h %h", $time, got, exp);
        end
    endtask
    // Grant shows on the edge after the wait count reaches the limit
    task automatic cmp_lat(input int got, input int lim);
        n_compared++;
        if (got != lim + 1) begin
            errors++;
            $display("mismatch %0t %h %h", $time, got, lim + 1);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        cmp(reg_rdata, exp);
    endtask
    task automatic end_sim;
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        begin : run_all
            repeat (12) @(posedge clock);
            rst <= 1'b0;
            for (int i = 0; i <= 10; i++) begin
                @(posedge clock);
                want <= (i < 10) ? rows[i][17:9] : 9'h000;
                #1;
                if (i > 0) begin
                    for (int b = 0; b < 9; b++) begin
                        if (rows[i-1][b]) begin
                            exp_owner = b;
                        end
                    end
                    cmp(32'(grant), 32'(rows[i-1][8:0]));
                    cmp(32'(owner), 32'(exp_owner));
                    cmp(32'(grant_high), 32'(|rows[i-1][8:0]));
                end
            end
            // Processor keeps winning until the other unit is raised
            for (int u = 0; u < 6; u++) begin
                slot = slots[u];
                wr(RAISE_DELAYS_ADDR, delays[u]);
                @(posedge clock);
                want <= 9'h001 | (9'h001 << slot);
                n = 0;
                do begin
                    @(posedge clock);
                    #1;
                    n++;
                end while (grant[slot] !== 1'b1 && n < 600);
                if (grant[slot] !== 1'b1) begin
                    errors++;
                    disable run_all;
                end
                cmp(32'(grant_high), 32'h1);
                @(posedge clock);
                want <= 9'h000;
                cmp_lat(n, lat[u]);
            end
            wr(RAISE_DELAYS_ADDR, 32'hFFFFFFFF);
            rd(RAISE_DELAYS_ADDR, 32'h000FFFFF);
            rd(32'h00100500, 32'h0);
            wr(BW_WEIGHT_ADDR, 32'hFFFFFFFF);
            rd(BW_WEIGHT_ADDR, 32'h0003FFFF);
            wr(BW_WEIGHT_ADDR, 32'h000090A9);
            rd(BW_WEIGHT_ADDR, 32'h000090A9);
            // Move the owner off zero so the reset below has something to clear
            @(posedge clock);
            want <= 9'h040;
            @(posedge clock);
            want <= 9'h000;
            @(posedge clock);
            rst <= 1'b1;
            @(posedge clock);
            rst <= 1'b0;
            #1;
            cmp(32'(grant), 32'h0);
            cmp(32'(owner), 32'h0);
            cmp(32'(grant_high), 32'h0);
            cmp(reg_rdata, 32'h0);
            rd(RAISE_DELAYS_ADDR, 32'h0);
            rd(BW_WEIGHT_ADDR, 32'h0);
            // Two low-class units take turns while neither has waited long
            wr(RAISE_DELAYS_ADDR, 32'h00008400);
            @(posedge clock);
            want <= 9'h00C;
            for (int c = 0; c < 4; c++) begin
                @(posedge clock);
                #1;
                cmp(32'(grant), (c % 2 == 0) ? 32'h4 : 32'h8);
                cmp(32'(owner), (c % 2 == 0) ? 32'h2 : 32'h3);
                cmp(32'(grant_high), 32'h0);
            end
            @(posedge clock);
            want <= 9'h000;
        end
        end_sim();
    end
endmodule

// ==== verification/request_units.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Requesting units on the far side
// ----------------------------------------
module request_units #(
    parameter int COP_WAIT = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [8:0] want,
    output logic [8:0] req,
    output logic [8:0] req_high
);
    logic [7:0] wait_cnt;
    // Units hold a request level for as long as they want a transfer
    assign req = want;
    // Only the coprocessor raises its own class; the rest show low on purpose
    assign req_high = {7'h00, wait_cnt >= 8'(COP_WAIT), 1'b0};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_cnt <= 8'h00;
        end else if (!want[1]) begin
            wait_cnt <= 8'h00;
        end else if (wait_cnt < 8'hFF) begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule
